// [hdl/mid_core.sv]
module mid_core #(
	parameter int STACK_DEPTH = 8
) (
	// clock and reset
	input  wire logic                        clk_in,
	input  wire logic                        sys_rst_in,
	// apb slave
	input  wire logic [11:0]                 paddr_in,
	input  wire logic                        psel_in,
	input  wire logic                        penable_in,
	input  wire logic                        pwrite_in,
	input  wire logic [31:0]                 pwdata_in,
	output logic      [31:0]                 prdata_out,
	output logic                             pready_out,
	output logic                             pslverr_out,
	// program memory
	output logic      [mid_pkg::PC_W-1:0]    prog_addr_out,
	input  wire logic [mid_pkg::INSTR_W-1:0] instr_in,
	// file registers
	output logic      [mid_pkg::FADDR_W-1:0] file_addr_out,
	output logic                             file_rd_out,
	input  wire logic [mid_pkg::DATA_W-1:0]  file_rdata_in,
	output logic                             file_wr_out,
	output logic      [mid_pkg::DATA_W-1:0]  file_wdata_out,
	// port pins and side effects
	input  wire logic [mid_pkg::DATA_W-1:0]  port_pins_in,
	output logic                             prescaler_clear_out,
	output logic                             watchdog_clear_out,
	output logic                             sleep_enter_out
);

	localparam int SP_W = $clog2(STACK_DEPTH);

	// opcode decode; don't-care bits are '?' so they never steer the result
	function automatic mid_pkg::mid_op_t decode(input logic [mid_pkg::INSTR_W-1:0] w);
		mid_pkg::mid_op_t op;
		op = mid_pkg::OP_IDLE;
		casez (w)
			14'b00_0000_0000_1000: op = mid_pkg::OP_RETURN;
			14'b00_0000_0000_1001: op = mid_pkg::OP_INT_RETURN;
			14'b00_0000_0110_0100: op = mid_pkg::OP_WDT_CLR;
			14'b00_0000_0110_0011: op = mid_pkg::OP_SLEEP;
			14'b00_0000_0??0_0000: op = mid_pkg::OP_IDLE;
			14'b00_0000_1???_????: op = mid_pkg::OP_STORE_ACC;
			14'b00_0001_1???_????: op = mid_pkg::OP_ZERO_FILE;
			14'b00_0001_0???_????: op = mid_pkg::OP_ZERO_ACC;
			14'b00_0010_????_????: op = mid_pkg::OP_SUB_FILE;
			14'b00_0011_????_????: op = mid_pkg::OP_DEC;
			14'b00_0100_????_????: op = mid_pkg::OP_OR;
			14'b00_0101_????_????: op = mid_pkg::OP_AND;
			14'b00_0110_????_????: op = mid_pkg::OP_XOR;
			14'b00_0111_????_????: op = mid_pkg::OP_ADD;
			14'b00_1000_????_????: op = mid_pkg::OP_COPY;
			14'b00_1001_????_????: op = mid_pkg::OP_INVERT;
			14'b00_1010_????_????: op = mid_pkg::OP_INC;
			14'b00_1011_????_????: op = mid_pkg::OP_DEC_SKIP;
			14'b00_1100_????_????: op = mid_pkg::OP_ROR;
			14'b00_1101_????_????: op = mid_pkg::OP_ROL;
			14'b00_1110_????_????: op = mid_pkg::OP_SWAP;
			14'b00_1111_????_????: op = mid_pkg::OP_INC_SKIP;
			14'b01_00??_????_????: op = mid_pkg::OP_BIT_CLR;
			14'b01_01??_????_????: op = mid_pkg::OP_BIT_SET;
			14'b01_10??_????_????: op = mid_pkg::OP_BIT_SKIP_CLR;
			14'b01_11??_????_????: op = mid_pkg::OP_BIT_SKIP_SET;
			14'b10_0???_????_????: op = mid_pkg::OP_CALL;
			14'b10_1???_????_????: op = mid_pkg::OP_JUMP;
			14'b11_00??_????_????: op = mid_pkg::OP_LOAD_LIT;
			14'b11_01??_????_????: op = mid_pkg::OP_RET_LIT;
			14'b11_1000_????_????: op = mid_pkg::OP_OR_LIT;
			14'b11_1001_????_????: op = mid_pkg::OP_AND_LIT;
			14'b11_1010_????_????: op = mid_pkg::OP_XOR_LIT;
			14'b11_110?_????_????: op = mid_pkg::OP_LIT_MINUS;
			14'b11_111?_????_????: op = mid_pkg::OP_ADD_LIT;
			default:               op = mid_pkg::OP_IDLE;
		endcase
		return op;
	endfunction : decode

	// true for every op that names a file register
	function automatic logic names_file(input mid_pkg::mid_op_t op);
		logic r;
		r = (op inside {[mid_pkg::OP_STORE_ACC:mid_pkg::OP_ZERO_FILE]})
			|| (op inside {[mid_pkg::OP_SUB_FILE:mid_pkg::OP_BIT_SKIP_SET]});
		return r;
	endfunction : names_file

	// 8-bit add with carry in, returns {carry, digit carry, sum}
	function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
		logic [4:0] lo;
		logic [4:0] hi;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
		return {hi[4], lo[4], hi[3:0], lo[3:0]};
	endfunction : add8

	mid_pkg::mid_phase_t            phase_q;
	logic [mid_pkg::INSTR_W-1:0]    ir_q;
	logic [mid_pkg::DATA_W-1:0]     data_q;
	logic [mid_pkg::DATA_W-1:0]     acc_q;
	logic [mid_pkg::PC_W-1:0]       pc_q;
	logic [mid_pkg::PC_W-1:0]       stack_q [STACK_DEPTH];
	logic [SP_W-1:0]                sp_q;
	logic                           c_q, dc_q, z_q, to_q, pwrdn_q, gie_q;
	logic                           flush_q, hold_q;
	logic [31:0]                    ctrl_q;
	logic [mid_pkg::DATA_W-1:0]     pin_meta_q, pin_sync_q;
	mid_pkg::mid_op_t               op;
	logic [mid_pkg::DATA_W-1:0]     res, mask;
	logic [9:0]                     sum;
	logic                           wr_file, wr_acc, upd_c, upd_dc, upd_z, skip;
	logic                           do_push, do_pop, do_jump;
	logic [mid_pkg::PC_W-1:0]       target;
	logic                           reg_hit;
	logic [31:0]                    reg_rdata;

	// phase counter: four clocks make one instruction cycle
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			phase_q <= mid_pkg::PH_Q1;
		end else begin
			phase_q <= mid_pkg::mid_phase_t'(phase_q + 2'h1);
		end
	end

	// pins come from outside, two flops before anything reads them
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			pin_meta_q <= 8'h00;
			pin_sync_q <= 8'h00;
		end else begin
			pin_meta_q <= port_pins_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// fetch at end of q1; a flushed or halted cycle runs as idle
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ir_q          <= mid_pkg::IDLE_WORD;
			file_addr_out <= 7'h00;
			file_rd_out   <= 1'b0;
		end else if (phase_q == mid_pkg::PH_Q1) begin
			if (flush_q || !ctrl_q[mid_pkg::CTRL_RUN_BIT]) begin
				ir_q        <= mid_pkg::IDLE_WORD;
				file_rd_out <= 1'b0;
			end else begin
				ir_q        <= instr_in;
				file_rd_out <= names_file(decode(instr_in));
			end
			file_addr_out <= instr_in[mid_pkg::FADDR_W-1:0];
		end else if (phase_q == mid_pkg::PH_Q2) begin
			file_rd_out <= 1'b0;
		end
	end

	// read phase, the port register returns pin levels instead of the latch
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			data_q <= 8'h00;
		end else if (phase_q == mid_pkg::PH_Q2) begin
			if (file_addr_out == mid_pkg::PORT_ADDR) begin
				data_q <= pin_sync_q;
			end else begin
				data_q <= file_rdata_in;
			end
		end
	end

	// execute: result, destination and flag updates for the held word
	always_comb begin
		op      = decode(ir_q);
		mask    = 8'h01 << ir_q[9:7];
		res     = 8'h00;
		sum     = 10'h000;
		wr_file = 1'b0;
		wr_acc  = 1'b0;
		upd_c   = 1'b0;
		upd_dc  = 1'b0;
		upd_z   = 1'b0;
		skip    = 1'b0;
		do_push = 1'b0;
		do_pop  = 1'b0;
		do_jump = 1'b0;
		target  = {ctrl_q[mid_pkg::CTRL_PAGE_LSB +: mid_pkg::CTRL_PAGE_W], ir_q[mid_pkg::JUMP_W-1:0]};
		case (op)
			mid_pkg::OP_ADD:      sum = add8(acc_q, data_q, 1'b0);
			mid_pkg::OP_SUB_FILE: sum = add8(data_q, ~acc_q, 1'b1);
			mid_pkg::OP_ADD_LIT:  sum = add8(acc_q, ir_q[7:0], 1'b0);
			mid_pkg::OP_LIT_MINUS: sum = add8(ir_q[7:0], ~acc_q, 1'b1);
			default:              sum = 10'h000;
		endcase
		case (op)
			mid_pkg::OP_ADD, mid_pkg::OP_SUB_FILE: begin
				res    = sum[7:0];
				upd_c  = 1'b1;
				upd_dc = 1'b1;
				upd_z  = 1'b1;
			end
			mid_pkg::OP_ADD_LIT, mid_pkg::OP_LIT_MINUS: begin
				res    = sum[7:0];
				wr_acc = 1'b1;
				upd_c  = 1'b1;
				upd_dc = 1'b1;
				upd_z  = 1'b1;
			end
			mid_pkg::OP_AND:      begin res = acc_q & data_q; upd_z = 1'b1; end
			mid_pkg::OP_OR:       begin res = acc_q | data_q; upd_z = 1'b1; end
			mid_pkg::OP_XOR:      begin res = acc_q ^ data_q; upd_z = 1'b1; end
			mid_pkg::OP_INVERT:   begin res = ~data_q; upd_z = 1'b1; end
			mid_pkg::OP_COPY:     begin res = data_q; upd_z = 1'b1; end
			mid_pkg::OP_INC:      begin res = data_q + 8'h01; upd_z = 1'b1; end
			mid_pkg::OP_DEC:      begin res = data_q - 8'h01; upd_z = 1'b1; end
			mid_pkg::OP_ROL:      begin res = {data_q[6:0], c_q}; upd_c = 1'b1; end
			mid_pkg::OP_ROR:      begin res = {c_q, data_q[7:1]}; upd_c = 1'b1; end
			mid_pkg::OP_SWAP:     res = {data_q[3:0], data_q[7:4]};
			mid_pkg::OP_DEC_SKIP: begin res = data_q - 8'h01; skip = (res == 8'h00); end
			mid_pkg::OP_INC_SKIP: begin res = data_q + 8'h01; skip = (res == 8'h00); end
			mid_pkg::OP_ZERO_FILE: begin res = 8'h00; wr_file = 1'b1; upd_z = 1'b1; end
			mid_pkg::OP_ZERO_ACC: begin res = 8'h00; wr_acc = 1'b1; upd_z = 1'b1; end
			mid_pkg::OP_STORE_ACC: begin res = acc_q; wr_file = 1'b1; end
			mid_pkg::OP_BIT_CLR:  begin res = data_q & ~mask; wr_file = 1'b1; end
			mid_pkg::OP_BIT_SET:  begin res = data_q | mask; wr_file = 1'b1; end
			mid_pkg::OP_BIT_SKIP_CLR: skip = ((data_q & mask) == 8'h00);
			mid_pkg::OP_BIT_SKIP_SET: skip = ((data_q & mask) != 8'h00);
			mid_pkg::OP_LOAD_LIT: begin res = ir_q[7:0]; wr_acc = 1'b1; end
			mid_pkg::OP_OR_LIT:   begin res = acc_q | ir_q[7:0]; wr_acc = 1'b1; upd_z = 1'b1; end
			mid_pkg::OP_AND_LIT:  begin res = acc_q & ir_q[7:0]; wr_acc = 1'b1; upd_z = 1'b1; end
			mid_pkg::OP_XOR_LIT:  begin res = acc_q ^ ir_q[7:0]; wr_acc = 1'b1; upd_z = 1'b1; end
			mid_pkg::OP_RET_LIT:  begin res = ir_q[7:0]; wr_acc = 1'b1; do_pop = 1'b1; end
			mid_pkg::OP_CALL:     begin do_push = 1'b1; do_jump = 1'b1; end
			mid_pkg::OP_JUMP:     do_jump = 1'b1;
			mid_pkg::OP_RETURN, mid_pkg::OP_INT_RETURN: do_pop = 1'b1;
			default:              res = 8'h00;
		endcase
		// d bit picks destination for the read-modify-write byte group
		if (op inside {[mid_pkg::OP_SUB_FILE:mid_pkg::OP_INC_SKIP]}) begin
			wr_file = ir_q[7];
			wr_acc  = !ir_q[7];
		end
	end

	// accumulator and status flags, updated at end of q3
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			acc_q <= mid_pkg::ACC_RESET;
			c_q   <= mid_pkg::FLAG_RESET;
			dc_q  <= mid_pkg::FLAG_RESET;
			z_q   <= mid_pkg::FLAG_RESET;
			to_q  <= mid_pkg::TOPD_RESET;
			pwrdn_q <= mid_pkg::TOPD_RESET;
			gie_q <= mid_pkg::FLAG_RESET;
		end else if (phase_q == mid_pkg::PH_Q3) begin
			if (wr_acc) acc_q <= res;
			if (upd_c) c_q <= (op inside {mid_pkg::OP_ROL, mid_pkg::OP_ROR}) ?
				(op == mid_pkg::OP_ROL ? data_q[7] : data_q[0]) : sum[9];
			if (upd_dc) dc_q <= sum[8];
			if (upd_z) z_q <= (res == 8'h00);
			if (op == mid_pkg::OP_WDT_CLR) begin
				to_q <= 1'b1;
				pwrdn_q <= 1'b1;
			end
			if (op == mid_pkg::OP_SLEEP) begin
				to_q <= 1'b1;
				pwrdn_q <= 1'b0;
			end
			if (op == mid_pkg::OP_INT_RETURN) gie_q <= 1'b1;
		end
	end

	// file write strobe and side-effect pulses stand for the q4 clock only
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			file_wr_out         <= 1'b0;
			file_wdata_out      <= 8'h00;
			prescaler_clear_out <= 1'b0;
			watchdog_clear_out  <= 1'b0;
			sleep_enter_out     <= 1'b0;
		end else if (phase_q == mid_pkg::PH_Q3) begin
			file_wr_out         <= wr_file;
			file_wdata_out      <= res;
			prescaler_clear_out <= wr_file && (file_addr_out == mid_pkg::TIMER_ZERO_ADDR)
				&& ctrl_q[mid_pkg::CTRL_PSA_BIT];
			watchdog_clear_out  <= (op == mid_pkg::OP_WDT_CLR);
			sleep_enter_out     <= (op == mid_pkg::OP_SLEEP);
		end else begin
			file_wr_out         <= 1'b0;
			prescaler_clear_out <= 1'b0;
			watchdog_clear_out  <= 1'b0;
			sleep_enter_out     <= 1'b0;
		end
	end

	// program counter, stack and two-cycle sequencing
	// a branch holds the pc through its idle cycle, a skip lets it advance past the discarded word
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			pc_q    <= mid_pkg::PC_RESET;
			sp_q    <= '0;
			flush_q <= 1'b0;
			hold_q  <= 1'b0;
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_q[i] <= mid_pkg::PC_RESET;
			end
		end else if (phase_q == mid_pkg::PH_Q3) begin
			flush_q <= skip || do_jump || do_pop;
			hold_q  <= do_jump || do_pop;
			if (do_push) begin
				stack_q[sp_q] <= pc_q + 13'h0001;
				sp_q          <= sp_q + 1'b1;
			end
			if (do_pop) begin
				sp_q <= sp_q - 1'b1;
				pc_q <= stack_q[sp_q - 1'b1];
			end else if (do_jump) begin
				pc_q <= target;
			end else if (!hold_q && ctrl_q[mid_pkg::CTRL_RUN_BIT]) begin
				pc_q <= pc_q + 13'h0001;
			end
		end
	end

	assign prog_addr_out = pc_q;

	// apb read mux; unmapped offsets answer with an error
	always_comb begin
		reg_hit   = 1'b1;
		reg_rdata = 32'h0000_0000;
		case (paddr_in)
			mid_pkg::OFS_CTRL:   reg_rdata = ctrl_q;
			mid_pkg::OFS_STATUS: begin
				reg_rdata[mid_pkg::ST_ACC_LSB +: mid_pkg::DATA_W] = acc_q;
				reg_rdata[mid_pkg::ST_C_BIT]   = c_q;
				reg_rdata[mid_pkg::ST_DC_BIT]  = dc_q;
				reg_rdata[mid_pkg::ST_Z_BIT]   = z_q;
				reg_rdata[mid_pkg::ST_TO_BIT]  = to_q;
				reg_rdata[mid_pkg::ST_PWRDN_BIT] = pwrdn_q;
				reg_rdata[mid_pkg::ST_GIE_BIT] = gie_q;
				reg_rdata[mid_pkg::ST_SP_LSB +: SP_W] = sp_q;
			end
			mid_pkg::OFS_PC:     reg_rdata[mid_pkg::PC_W-1:0] = pc_q;
			default:             reg_hit = 1'b0;
		endcase
	end

	// apb answer: ready is set from the setup phase, so it stands in the first access clock, all outputs from flops
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
		end else if (psel_in && !penable_in) begin
			pready_out  <= 1'b1;
			pslverr_out <= !reg_hit;
			prdata_out  <= (reg_hit && !pwrite_in) ? reg_rdata : 32'h0000_0000;
		end else begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
		end
	end

	// control register; only the documented low bits are writable
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ctrl_q <= mid_pkg::CTRL_RESET;
		end else if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == mid_pkg::OFS_CTRL) begin
			ctrl_q <= pwdata_in & mid_pkg::CTRL_WR_MASK;
		end
	end

endmodule : mid_core

// [hdl/mid_pkg.sv]
package mid_pkg;

	// word and field widths
	localparam int INSTR_W = 14;
	localparam int DATA_W  = 8;
	localparam int FADDR_W = 7;
	localparam int PC_W    = 13;
	localparam int LIT_W   = 8;
	localparam int JUMP_W  = 11;

	// register map, byte addresses on the bus
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_PC     = 12'h008;

	// control register fields and value after reset
	localparam int          CTRL_RUN_BIT   = 0;
	localparam int          CTRL_PSA_BIT   = 1;
	localparam int          CTRL_PAGE_LSB  = 2;
	localparam int          CTRL_PAGE_W    = 2;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
	localparam logic [31:0] CTRL_WR_MASK   = 32'h0000_000f;

	// status register fields
	localparam int ST_ACC_LSB = 0;
	localparam int ST_C_BIT   = 8;
	localparam int ST_DC_BIT  = 9;
	localparam int ST_Z_BIT   = 10;
	localparam int ST_TO_BIT  = 11;
	localparam int ST_PWRDN_BIT = 12;
	localparam int ST_GIE_BIT = 13;
	localparam int ST_SP_LSB  = 16;

	// file addresses with side effects
	localparam logic [FADDR_W-1:0] TIMER_ZERO_ADDR = 7'h01;
	localparam logic [FADDR_W-1:0] PORT_ADDR       = 7'h05;

	// values after reset
	localparam logic [DATA_W-1:0]  ACC_RESET  = 8'h00;
	localparam logic [PC_W-1:0]    PC_RESET   = 13'h0000;
	localparam logic [INSTR_W-1:0] IDLE_WORD  = 14'h0000;
	localparam logic               FLAG_RESET = 1'b0;
	localparam logic               TOPD_RESET = 1'b1;

	// oscillator periods per instruction cycle
	localparam int PHASES_PER_CYCLE = 4;

	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} mid_phase_t;

	typedef enum logic [5:0] {
		OP_IDLE = 6'h00, OP_STORE_ACC = 6'h01, OP_ZERO_FILE = 6'h02, OP_ZERO_ACC = 6'h03,
		OP_SUB_FILE = 6'h04, OP_DEC = 6'h05, OP_OR = 6'h06, OP_AND = 6'h07,
		OP_XOR = 6'h08, OP_ADD = 6'h09, OP_COPY = 6'h0a, OP_INVERT = 6'h0b,
		OP_INC = 6'h0c, OP_DEC_SKIP = 6'h0d, OP_ROR = 6'h0e, OP_ROL = 6'h0f,
		OP_SWAP = 6'h10, OP_INC_SKIP = 6'h11, OP_BIT_CLR = 6'h12, OP_BIT_SET = 6'h13,
		OP_BIT_SKIP_CLR = 6'h14, OP_BIT_SKIP_SET = 6'h15, OP_CALL = 6'h16, OP_JUMP = 6'h17,
		OP_LOAD_LIT = 6'h18, OP_RET_LIT = 6'h19, OP_OR_LIT = 6'h1a, OP_AND_LIT = 6'h1b,
		OP_XOR_LIT = 6'h1c, OP_LIT_MINUS = 6'h1d, OP_ADD_LIT = 6'h1e, OP_RETURN = 6'h1f,
		OP_INT_RETURN = 6'h20, OP_WDT_CLR = 6'h21, OP_SLEEP = 6'h22
	} mid_op_t;

endpackage : mid_pkg

// [test/mid_core_monitor.sv]
module mid_core_monitor (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        sys_rst_in,
	// watched ports
	input wire logic [13:0] instr_in,
	input wire logic [6:0]  file_addr_out,
	input wire logic        file_rd_out,
	input wire logic        file_wr_out,
	input wire logic        prescaler_clear_out,
	input wire logic        watchdog_clear_out,
	input wire logic        sleep_enter_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0]  ph_q;
	logic [13:0] ir_q;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// own phase count from release, so no internals are needed
	always_ff @(posedge clk_in) begin
		if (sys_rst_in)
			ph_q <= 2'h0;
		else
			ph_q <= ph_q + 2'h1;
	end
	// copy of the word taken at the end of phase one
	always_ff @(posedge clk_in) begin
		if (ph_q == 2'h0)
			ir_q <= instr_in;
	end
	property p_rd_phase; file_rd_out |-> ph_q == 2'h1; endproperty
	a_rd_phase: assert property (p_rd_phase) else $error("file read out of phase");
	property p_wr_phase; file_wr_out |-> ph_q == 2'h3; endproperty
	a_wr_phase: assert property (p_wr_phase) else $error("file write out of phase");
	property p_rmw; file_wr_out |-> $past(file_rd_out, 2) && $stable(file_addr_out); endproperty
	a_rmw: assert property (p_rmw) else $error("write without prior read");
	property p_faddr; file_rd_out |-> file_addr_out == ir_q[6:0] && ir_q[13] == 1'b0; endproperty
	a_faddr: assert property (p_faddr) else $error("file address not from word");
	property p_dest; file_wr_out |-> ir_q[7] || ir_q[13:12] == 2'b01; endproperty
	a_dest: assert property (p_dest) else $error("file written with d clear");
	property p_idle; (ph_q == 2'h0 && instr_in[13:7] == 7'h00 && instr_in[4:0] == 5'h00)
		|=> !file_rd_out ##2 !file_wr_out; endproperty
	a_idle: assert property (p_idle) else $error("idle word touched files");
	property p_lit; (ph_q == 2'h1 && ir_q[13:12] == 2'b11) |-> (!file_rd_out && !file_wr_out) [*3]; endproperty
	a_lit: assert property (p_lit) else $error("literal op touched files");
	property p_presc; prescaler_clear_out |-> file_wr_out && file_addr_out == mid_pkg::TIMER_ZERO_ADDR; endproperty
	a_presc: assert property (p_presc) else $error("prescaler clear without timer write");
	property p_wdt; watchdog_clear_out |-> ph_q == 2'h3 && ir_q == 14'h0064; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog clear without its word");
	property p_sleep; sleep_enter_out |-> ir_q == 14'h0063 ##1 !sleep_enter_out; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep pulse wrong");
	// main scenarios reached
	c_presc: cover property (prescaler_clear_out);
	c_wdt: cover property (watchdog_clear_out);
	c_skip_wr: cover property (file_wr_out && ir_q[13:8] == 6'h0b);
endmodule : mid_core_monitor

bind mid_core mid_core_monitor i_mid_core_monitor (.clk_in, .sys_rst_in, .instr_in, .file_addr_out, .file_rd_out,
	.file_wr_out, .prescaler_clear_out, .watchdog_clear_out, .sleep_enter_out);

// [test/mid_prog_mem.sv]
module mid_prog_mem (
	// clock
	input  wire logic        clk_in,
	// program side
	input  wire logic [12:0] prog_addr_in,
	output logic      [13:0] instr_out,
	// file side
	input  wire logic [6:0]  file_addr_in,
	input  wire logic        file_rd_in,
	input  wire logic        file_wr_in,
	input  wire logic [7:0]  file_wdata_in,
	output logic      [7:0]  file_rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [13:0] mem [0:1023];
	logic [7:0]  regs [0:127];
	// fetch wraps within the implemented space
	assign instr_out = mem[prog_addr_in[9:0]];
	// inverted outside the read strobe, so a late or early sample shows
	assign file_rdata_out = file_rd_in ? regs[file_addr_in] : ~regs[file_addr_in];
	// store on the core's write strobe
	always @(posedge clk_in) begin
		if (file_wr_in === 1'b1)
			regs[file_addr_in] <= file_wdata_in;
	end
endmodule : mid_prog_mem

// [test/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NI = 112;
	localparam int LA = NI + 4;
	logic        clk_in = 1'b0, sys_rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
	logic        pready_out, pslverr_out, file_rd_out, file_wr_out, prescaler_clear_out, watchdog_clear_out;
	logic        sleep_enter_out, er;
	logic [12:0] prog_addr_out;
	logic [13:0] instr_in;
	logic [6:0]  file_addr_out;
	logic [7:0]  file_rdata_in, file_wdata_out, port_pins_in = 8'h00;
	int          n_fail, checks_done, seed, clk_n, acc, c, dc, z, to, pwrdn, gie, cyc;
	int          npre, nwdt, nslp, spre, swdt, sslp;
	int          pm[0:1023], fm[0:127], exp_q[$];

	always #2 clk_in = ~clk_in;

	mid_core i_mid_core (.clk_in, .sys_rst_in, .paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in, .prdata_out,
		.pready_out, .pslverr_out, .prog_addr_out, .instr_in, .file_addr_out, .file_rd_out, .file_rdata_in,
		.file_wr_out, .file_wdata_out, .port_pins_in, .prescaler_clear_out, .watchdog_clear_out, .sleep_enter_out);
	mid_prog_mem i_mid_prog_mem (.clk_in, .prog_addr_in(prog_addr_out), .instr_out(instr_in),
		.file_addr_in(file_addr_out), .file_rd_in(file_rd_out), .file_wr_in(file_wr_out),
		.file_wdata_in(file_wdata_out), .file_rdata_out(file_rdata_in));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic close_out();
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	// one apb transfer, held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= wd;
		@(posedge clk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 16);
		n_fail += n >= 16;
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb

	function automatic int addc(int a, int b, int ci);
		c = (a + b + ci) >> 8;
		dc = (a & 15) + (b & 15) + ci > 15;
		return a + b + ci & 255;
	endfunction : addc

	// program: every byte code, literal code, bit operation and special word in turn, with random bit selectors
	task automatic gen();
		int r, f, k;
		int bops[14] = '{7, 5, 2, 4, 6, 9, 3, 10, 8, 13, 12, 14, 11, 15};
		int spc[7] = '{14'h0064, 14'h0063, 14'h0062, 14'h0000, 14'h0020, 14'h0040, 14'h0060};
		for (int i = 0; i < NI; i++) begin
			r = $random(seed) & 32'hffff;
			f = r % 6 < 4 ? 32 + r % 6 : (r % 6 == 4 ? 1 : 5);
			k = i / 8 * 2 + i % 8;
			case (i % 8)
				0, 1: pm[i + 4] = bops[k % 14] << 8 | r & 32'h80 | f;
				2: pm[i + 4] = k % 3 == 0 ? 32'h0180 | f : (k % 3 == 1 ? 32'h0100 | r & 32'h7f : 32'h0080 | f);
				3: pm[i + 4] = 32'h1000 | i / 8 % 4 << 10 | r & 32'h380 | f;
				4, 5: pm[i + 4] = 32'h3000 | (k % 16 / 4 == 1 ? k % 16 + 8 : k % 16) << 8 | r & 255;
				6: pm[i + 4] = spc[i / 8 % 7];
				default: pm[i + 4] = i / 8 % 4 == 1 ? 32'h2000 | LA + 1 + i / 8 % 3 : 32'h2800 | i + 5;
			endcase
		end
		pm[LA] = 32'h2800 | LA;
		// subroutines past the end: plain return, return with literal, interrupt return
		pm[LA + 1] = 32'h0008;
		pm[LA + 2] = 32'h3500 | $random(seed) & 255;
		pm[LA + 3] = 32'h0009;
		foreach (pm[a]) i_mid_prog_mem.mem[a] = pm[a][13:0];
	endtask : gen

	// reference execution: expected writes with their clock, flags and pulse counts
	task automatic model();
		int pc, w, f, op, r, res, dst, skip, b, nx;
		int stk[$];
		to = 1;
		pwrdn = 1;
		while (pc != LA) begin
			w = pm[pc];
			f = w & 127;
			op = w >> 8 & 15;
			b = w >> 7 & 7;
			r = f == 5 ? port_pins_in : fm[f];
			{dst, skip, res, nx} = {32'd0, 32'd0, 32'd0, pc + 1};
			case (w >> 12)
				0: begin
					dst = op < 2 ? 0 : 1 + (w >> 7 & 1);
					case (op)
						0: if (w & 32'h80) {res, dst} = {acc, 32'd2};
							else if (w == 14'h0064) {to, pwrdn, nwdt} = {32'd1, 32'd1, nwdt + 1};
							else if (w == 14'h0063) {to, pwrdn, nslp} = {32'd1, 32'd0, nslp + 1};
							else if ((w | 1) == 9) {nx, cyc, gie} = {stk.pop_back(), cyc + 1, gie | w & 1};
						1: {dst, z} = {32'd1 + (w >> 7 & 1), 32'd1};
						2: res = addc(r, ~acc & 255, 1);
						3, 11: res = r - 1 & 255;
						4: res = acc | r;
						5: res = acc & r;
						6: res = acc ^ r;
						7: res = addc(acc, r, 0);
						8: res = r;
						9: res = ~r & 255;
						12: {res, c} = {c << 7 | r >> 1, r & 1};
						13: {res, c} = {(r << 1 | c) & 255, r >> 7};
						14: res = (r << 4 | r >> 4) & 255;
						default: res = r + 1 & 255;
					endcase
					skip = (op == 11 || op == 15) && res == 0;
					if (op >= 2 && op <= 10) z = res == 0;
				end
				1: case (w >> 10 & 3)
					0: {res, dst} = {r & ~(1 << b), 32'd2};
					1: {res, dst} = {r | 1 << b, 32'd2};
					2: skip = (r >> b & 1) == 0;
					default: skip = r >> b & 1;
				endcase
				2: begin
					if (!(w & 32'h800)) stk.push_back(pc + 1);
					{nx, cyc} = {w & 2047, cyc + 1};
				end
				default: begin
					dst = op != 11;
					case (op)
						8: res = acc | w & 255;
						9: res = acc & w & 255;
						10: res = acc ^ w & 255;
						12, 13: res = addc(w & 255, ~acc & 255, 1);
						14, 15: res = addc(acc, w & 255, 0);
						default: res = w & 255;
					endcase
					if (op >> 2 == 1) {nx, cyc} = {stk.pop_back(), cyc + 1};
					if (op >= 8 && op != 11) z = res == 0;
				end
			endcase
			if (dst == 1) acc = res;
			if (dst == 2) begin
				exp_q.push_back((4 * cyc + 3) << 16 | f << 8 | res);
				fm[f] = res;
				npre += f == 1;
			end
			cyc += skip + 1;
			pc = nx + skip;
		end
	endtask : model

	// every file write is matched against the model, with its clock
	always @(posedge clk_in) begin
		if (sys_rst_in)
			clk_n <= 0;
		else begin
			clk_n <= clk_n + 1;
			spre <= spre + prescaler_clear_out;
			swdt <= swdt + watchdog_clear_out;
			sslp <= sslp + sleep_enter_out;
			if (file_wr_out === 1'b1)
				chk("fwr", {clk_n[15:0], 1'b0, file_addr_out, file_wdata_out}, exp_q.size() ? exp_q.pop_front() : 0);
		end
	end

	initial begin
		seed = 19;
		port_pins_in = $random(seed);
		foreach (fm[i]) fm[i] = $random(seed) & 255;
		foreach (fm[i]) i_mid_prog_mem.regs[i] = fm[i][7:0];
		i_mid_prog_mem.regs[5] = ~port_pins_in;
		gen();
		model();
		repeat (8) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		apb(1'b0, mid_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", rd, mid_pkg::CTRL_RESET);
		apb(1'b1, mid_pkg::OFS_CTRL, 32'hffff_fff3);
		apb(1'b1, mid_pkg::OFS_STATUS, 32'h0);
		apb(1'b0, mid_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", rd, 32'h3);
		apb(1'b0, 12'h00c, 32'h0);
		chk("err", {31'h0, er}, 32'h1);
		while (clk_n < 4 * cyc + 8) @(posedge clk_in);
		apb(1'b0, mid_pkg::OFS_STATUS, 32'h0);
		chk("status", rd & 32'h7_1fff, pwrdn << 12 | to << 11 | z << 10 | dc << 9 | c << 8 | acc);
		chk("gie", rd >> 13 & 1, gie);
		apb(1'b0, mid_pkg::OFS_PC, 32'h0);
		chk("pc", rd, LA);
		chk("left", exp_q.size(), 0);
		chk("presc", spre, npre);
		chk("wdt", swdt, nwdt);
		chk("sleep", sslp, nslp);
		close_out();
	end

	// hang guard, far beyond the expected run
	initial begin
		#20000;
		n_fail++;
		close_out();
	end
endmodule : tb
